// ==== quad_cfg.svh ====
// Constants for the quadrature encoder counter
`ifndef QUAD_CFG_SVH
`define QUAD_CFG_SVH

`define QUAD_CHANNELS 5
`define QUAD_MASTER_CH 4
`define QUAD_POS_WIDTH 32
`define QUAD_VEL_WIDTH 16
`define QUAD_CLK_HZ 10000000
`define QUAD_MAX_COUNT_HZ 8000000
`define QUAD_MAX_PHASE_HZ 2000000
`define QUAD_VEL_WINDOW_US 100
`define QUAD_VEL_WINDOW_CYC ((`QUAD_VEL_WINDOW_US * (`QUAD_CLK_HZ / 1000000)) > 0 ? \
    (`QUAD_VEL_WINDOW_US * (`QUAD_CLK_HZ / 1000000)) : 1)
`define QUAD_WIN_CNT_WIDTH 16
`define QUAD_POS_RESET 32'h0000_0000
`define QUAD_VEL_RESET 16'h0000
`define QUAD_DELTA_ONE 16'h0001
`define QUAD_WIN_ZERO 16'h0000
`define QUAD_WIN_ONE 16'h0001
`define QUAD_FILL_WIDTH 3
`define QUAD_FILL_RESET 3'h0

`endif

// ==== quad_pkg.sv ====
// Types shared by the quadrature encoder counter
`default_nettype none
package quad_pkg;
`include "quad_cfg.svh"
    typedef logic [`QUAD_CHANNELS-1:0] chan_mask_type;
    typedef logic [`QUAD_POS_WIDTH-1:0] position_type;
    typedef logic [`QUAD_VEL_WIDTH-1:0] velocity_type;
endpackage
`default_nettype wire

// ==== quadrature_encoder_counter.sv ====
// Five-channel quadrature decoder with position and velocity per channel
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg.svh"

// Functional notes
// - Five channels: axes 0 to 3, channel 4 is the master reference.
// - Each channel takes phase A, phase B and an index mark.
// - A leading B counts up; B leading A counts down.
// - Every edge of A or B alone in its sample counts, four per cycle, into position.
// - Phase rate at most 2 MHz, 8 million counts per second.
// - Velocity is counted edges per fixed time window.
// - Missing index never faults; counting uses A and B only.
module quadrature_encoder_counter (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire quad_pkg::chan_mask_type i_phase_a_input,
    input wire quad_pkg::chan_mask_type i_phase_b_input,
    input wire quad_pkg::chan_mask_type i_index_input,
    output quad_pkg::position_type o_position [`QUAD_CHANNELS],
    output quad_pkg::velocity_type o_velocity [`QUAD_CHANNELS],
    output quad_pkg::chan_mask_type o_direction_up,
    output quad_pkg::chan_mask_type o_count_pulse,
    output quad_pkg::chan_mask_type o_index_pulse,
    output quad_pkg::chan_mask_type o_phase_error,
    output logic o_window_pulse
);
    import quad_pkg::*;

    // ------------------------------------------------------------
    // Velocity window timebase, shared by all channels
    // ------------------------------------------------------------
    // One count in a 1000-cycle window is 10 kcount/s: a coarse
    // figure, traded for a fast velocity update
    localparam logic [`QUAD_WIN_CNT_WIDTH-1:0] WIN_LAST = `QUAD_WIN_CNT_WIDTH'(`QUAD_VEL_WINDOW_CYC - 1);
    logic [`QUAD_WIN_CNT_WIDTH-1:0] win_cnt_reg;
    logic win_end;

    assign win_end = (win_cnt_reg == WIN_LAST);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            win_cnt_reg <= `QUAD_WIN_ZERO;
        end else if (win_end) begin
            win_cnt_reg <= `QUAD_WIN_ZERO;
        end else begin
            win_cnt_reg <= win_cnt_reg + `QUAD_WIN_ONE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_window_pulse <= 1'b0;
        end else begin
            o_window_pulse <= win_end;
        end
    end

    // ------------------------------------------------------------
    // Start-up guard, shared by all channels
    // ------------------------------------------------------------
    // Synchroniser and history zeros after reset are not pin levels;
    // edges are ignored until both hold real samples
    logic [`QUAD_FILL_WIDTH-1:0] fill_reg;
    logic armed;

    assign armed = fill_reg[`QUAD_FILL_WIDTH-1];

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            fill_reg <= `QUAD_FILL_RESET;
        end else begin
            fill_reg <= {fill_reg[`QUAD_FILL_WIDTH-2:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Per-channel decoder, one copy per encoder
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `QUAD_CHANNELS; ch = ch + 1) begin : g_chan
            // Two-stage synchronisers, then one history stage for edges
            logic [1:0] a_sync_reg;
            logic [1:0] b_sync_reg;
            logic [1:0] i_sync_reg;
            logic a_prev_reg;
            logic b_prev_reg;
            logic i_prev_reg;
            logic a_now;
            logic b_now;
            logic a_chg;
            logic b_chg;
            logic step;
            logic step_up;
            logic both_chg;
            velocity_type delta_reg;
            logic idx_rise;

            assign a_now = a_sync_reg[1];
            assign b_now = b_sync_reg[1];
            assign a_chg = a_now ^ a_prev_reg;
            assign b_chg = b_now ^ b_prev_reg;
            // Exactly one phase moved: a valid quadrature step.
            // Each edge needs a sample of its own, so 8 Mcount/s is marginal
            assign step = armed & (a_chg ^ b_chg);
            // Direction from which phase leads, valid only on a single step
            assign step_up = a_now ^ b_prev_reg;
            // Direction lost when both move in one sample
            assign both_chg = armed & a_chg & b_chg;
            // Index edge, for reporting only
            assign idx_rise = armed & i_sync_reg[1] & ~i_prev_reg;

            // --------------------------------------------------------
            // Input capture
            // --------------------------------------------------------
            // Two flip-flops per pin before any logic reads it
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    a_sync_reg <= 2'h0;
                    b_sync_reg <= 2'h0;
                    i_sync_reg <= 2'h0;
                end else begin
                    a_sync_reg <= {a_sync_reg[0], i_phase_a_input[ch]};
                    b_sync_reg <= {b_sync_reg[0], i_phase_b_input[ch]};
                    i_sync_reg <= {i_sync_reg[0], i_index_input[ch]};
                end
            end

            // History is compared only once armed, so a phase already
            // high at reset makes no false count
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    a_prev_reg <= 1'b0;
                    b_prev_reg <= 1'b0;
                    i_prev_reg <= 1'b0;
                end else begin
                    a_prev_reg <= a_now;
                    b_prev_reg <= b_now;
                    i_prev_reg <= i_sync_reg[1];
                end
            end

            // --------------------------------------------------------
            // Position and direction
            // --------------------------------------------------------
            // Two's complement wrap, no saturation
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_position[ch] <= `QUAD_POS_RESET;
                end else if (step) begin
                    o_position[ch] <= step_up ? o_position[ch] + position_type'(1)
                                              : o_position[ch] - position_type'(1);
                end
            end

            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_direction_up[ch] <= 1'b1;
                end else if (step) begin
                    o_direction_up[ch] <= step_up;
                end
            end

            // --------------------------------------------------------
            // Event pulses
            // --------------------------------------------------------
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_count_pulse[ch] <= 1'b0;
                end else begin
                    o_count_pulse[ch] <= step;
                end
            end

            // A pulse per lost step, not sticky
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_phase_error[ch] <= 1'b0;
                end else begin
                    o_phase_error[ch] <= both_chg;
                end
            end

            // Index is reported only; it never resets position nor faults
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_index_pulse[ch] <= 1'b0;
                end else begin
                    o_index_pulse[ch] <= idx_rise;
                end
            end

            // --------------------------------------------------------
            // Velocity
            // --------------------------------------------------------
            // Signed edge count over the window; a step on the closing
            // cycle starts the next window so no edge is lost
            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    delta_reg <= `QUAD_VEL_RESET;
                end else if (win_end) begin
                    delta_reg <= !step ? `QUAD_VEL_RESET :
                                 (step_up ? `QUAD_DELTA_ONE : -`QUAD_DELTA_ONE);
                end else if (step) begin
                    delta_reg <= step_up ? delta_reg + `QUAD_DELTA_ONE
                                         : delta_reg - `QUAD_DELTA_ONE;
                end
            end

            always_ff @(posedge i_core_clk) begin
                if (i_reset) begin
                    o_velocity[ch] <= `QUAD_VEL_RESET;
                end else if (win_end) begin
                    o_velocity[ch] <= delta_reg;
                end
            end
        end
    endgenerate

endmodule // quadrature_encoder_counter
`default_nettype wire

// ==== quad_enc_model.sv ====
// Encoder model: two phases a quarter cycle apart per channel
`timescale 1ns/1ps
`default_nettype none
module enc_model (
    output logic [4:0] o_a,
    output logic [4:0] o_b
);
    logic [1:0] q [5] = '{default: 2'h0};
    // Step 2'h1 up, 2'h3 down; 2'h2 moves both phases at once
    task automatic move(input int ch, input logic [1:0] d);
        q[ch] = q[ch] + d;
    endtask
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            o_a[i] = q[i][0] ^ q[i][1];
            o_b[i] = q[i][1];
        end
    end
endmodule // enc_model
`default_nettype wire

// ==== quad_props.sv ====
// Checker for the quadrature encoder counter
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg.svh"
module quad_props (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire quad_pkg::chan_mask_type i_phase_a_input,
    input wire quad_pkg::chan_mask_type i_phase_b_input,
    input wire quad_pkg::chan_mask_type i_index_input,
    input wire quad_pkg::position_type o_position [`QUAD_CHANNELS],
    input wire quad_pkg::velocity_type o_velocity [`QUAD_CHANNELS],
    input wire quad_pkg::chan_mask_type o_direction_up,
    input wire quad_pkg::chan_mask_type o_count_pulse,
    input wire quad_pkg::chan_mask_type o_index_pulse,
    input wire quad_pkg::chan_mask_type o_phase_error,
    input wire logic o_window_pulse
);
    import quad_pkg::*;
    // ----
    // Checks
    // ----
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    up_step_a: assert property (o_count_pulse[0] && o_direction_up[0] |->
        o_position[0] == $past(o_position[0]) + 1) else $error("bad up step");
    down_step_a: assert property (o_count_pulse[0] && !o_direction_up[0] |->
        o_position[0] == $past(o_position[0]) - 1) else $error("bad down step");
    master_step_a: assert property (o_count_pulse[4] && o_direction_up[4] |->
        o_position[4] == $past(o_position[4]) + 1) else $error("bad master step");
    count_cause_a: assert property ($changed(i_phase_a_input[0]) && $stable(i_phase_b_input[0]) |->
        ##[1:4] o_count_pulse[0]) else $error("edge not counted");
    err_cause_a: assert property ($changed(i_phase_a_input[1]) && $changed(i_phase_b_input[1]) |->
        ##[1:4] o_phase_error[1]) else $error("no phase error");
    err_nocount_a: assert property (o_phase_error[1] |->
        !o_count_pulse[1] && o_position[1] == $past(o_position[1])) else $error("count on error");
    index_seen_a: assert property ($rose(i_index_input[0]) |-> ##[1:4] o_index_pulse[0])
        else $error("index missed");
    vel_update_a: assert property ($changed(o_velocity[2]) |-> o_window_pulse)
        else $error("velocity off window");
    cover property (o_phase_error[1]);
    cover property (o_window_pulse && o_velocity[2] != 16'h0);
    cover property (o_count_pulse[4]);
    cover property (o_index_pulse[0]);
endmodule // quad_props
bind quadrature_encoder_counter quad_props u_props (.*);
`default_nettype wire

// ==== tb.sv ====
// Testbench for the quadrature encoder counter
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg.svh"
module tb;
    import quad_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    chan_mask_type pa, pb, dir, cnt, ipl, err;
    chan_mask_type idx = 5'h00;
    position_type pos [`QUAD_CHANNELS];
    velocity_type vel [`QUAD_CHANNELS];
    logic win;
    int n_mismatch = 0;
    int checked = 0;
    always #50 i_core_clk = ~i_core_clk;
    enc_model enc (.o_a(pa), .o_b(pb));
    quadrature_encoder_counter DUT (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_phase_a_input(pa),
        .i_phase_b_input(pb), .i_index_input(idx), .o_position(pos), .o_velocity(vel), .o_direction_up(dir),
        .o_count_pulse(cnt), .o_index_pulse(ipl), .o_phase_error(err), .o_window_pulse(win));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int ch, inout int pulses, inout int marks);
        @(negedge i_core_clk);
        pulses += int'(cnt[ch]);
        marks += int'(ipl[ch]);
    endtask
    // Each edge gets a sample of its own down to a gap of 1 cycle
    task automatic steps(input int ch, input int n, input logic [1:0] d, input int gap,
        output int pulses, output int marks);
        pulses = 0;
        marks = 0;
        repeat (n) begin
            tick(ch, pulses, marks);
            enc.move(ch, d);
            repeat (gap - 1) tick(ch, pulses, marks);
        end
        repeat (5) tick(ch, pulses, marks);
    endtask
    task automatic wait_win();
        for (int i = 0; i < 1100 && win !== 1'b1; i++) @(negedge i_core_clk);
        if (win !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic s_err();
        logic seen;
        seen = 1'b0;
        @(negedge i_core_clk);
        enc.move(1, 2'h2);
        repeat (5) begin
            @(negedge i_core_clk);
            seen |= err[1];
        end
        chk("phase error", {31'h0, seen}, 32'h1);
        chk("position 1", pos[1], 32'hffff_fffe);
    endtask
    task automatic s_chan(input int ch);
        int p;
        int m;
        steps(ch, 4, 2'h1, 3, p, m);
        chk("position up", pos[ch], 32'h4);
        chk("up pulses", p, 32'h4);
        steps(ch, 6, 2'h3, 3, p, m);
        chk("position down", pos[ch], 32'hffff_fffe);
        chk("down pulses", p, 32'h6);
        chk("direction", {27'h0, dir}, {27'h0, 5'h1f << (ch + 1)});
        chk("no index", m, 32'h0);
    endtask
    task automatic s_fast();
        int p;
        int m;
        idx = 5'h01;
        steps(0, 8, 2'h1, 2, p, m);
        idx = 5'h00;
        chk("position fast", pos[0], 32'h6);
        chk("fast pulses", p, 32'h8);
        chk("index pulse", m, 32'h1);
    endtask
    task automatic s_vel();
        int p;
        int m;
        wait_win();
        steps(2, 5, 2'h1, 3, p, m);
        wait_win();
        chk("velocity", {16'h0, vel[2]}, 32'h5);
    endtask
    // Phases left high through reset must not look like edges
    task automatic s_reset();
        logic seen;
        seen = 1'b0;
        i_reset = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk("reset position", pos[0], 32'h0);
        chk("reset velocity", {16'h0, vel[2]}, 32'h0);
        chk("reset direction", {27'h0, dir}, 32'h1f);
        i_reset = 1'b0;
        repeat (8) begin
            @(negedge i_core_clk);
            seen |= (|cnt) | (|err);
        end
        chk("false edge", {31'h0, seen}, 32'h0);
        chk("position held", pos[2], 32'h0);
    endtask
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_reset = 1'b0;
        for (int ch = 0; ch < `QUAD_CHANNELS; ch++) begin
            s_chan(ch);
        end
        s_fast();
        s_err();
        s_vel();
        s_reset();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
